// *** core/alu_cfg.svh ***
// Offsets, field positions, reset values and answer codes for the ALU block.
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ACC_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define CTRL_OFFSET 8'h08
`define INFO_OFFSET 8'h0c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_ENABLE_BIT 0
`define INFO_BUSY_BIT 8
`define STATUS_WIDTH 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACC_RESET 8'h00
`define FLAGS_RESET 6'h00
`define ENABLE_RESET 1'h1
`define SKIP_COUNT_RESET 8'h00

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** core/alu_pkg.sv ***
// Types shared by the ALU execution block and its helpers.
package alu_pkg;

  // Instructions this datapath executes.
  typedef enum logic [2:0] {
    skip_if_nonzero_op,
    subtract_acc_op,
    subtract_to_memory_op,
    subtract_imm_op,
    swap_nibbles_op
  } op_t;

  // Status flags; carry sits in bit 0.
  typedef struct packed {
    logic compare_zero_flag;
    logic signed_compare_flag;
    logic overflow_flag;
    logic zero_flag;
    logic auxiliary_borrow_flag;
    logic carry_flag;
  } flags_t;

  // Instruction handed over by the decoder.
  typedef struct packed {
    logic valid;
    op_t op;
    logic [7:0] addr;
    logic [7:0] literal;
  } op_req_t;

  // Data memory request.
  typedef struct packed {
    logic rd_en;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  // AXI4-Lite master to slave.
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  // AXI4-Lite slave to master.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage

// *** core/sub_unit.sv ***
// Eight-bit subtractor with the full set of status flags.
`timescale 1ns/1ns
`default_nettype none
module sub_unit
(
  // Operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  // Result
  output logic [7:0] difference,
  output alu_pkg::flags_t flags
);
  import alu_pkg::*;

  logic [8:0] wide;
  logic [4:0] low;

  // Extra top bit of each partial difference is the borrow out.
  assign wide = {1'b0, minuend} - {1'b0, subtrahend};
  assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
  assign difference = wide[7:0];

  assign flags.carry_flag = ~wide[8];
  assign flags.auxiliary_borrow_flag = ~low[4];
  assign flags.zero_flag = (wide[7:0] == 8'h00);
  assign flags.overflow_flag = (minuend[7] ^ subtrahend[7]) &
                               (minuend[7] ^ wide[7]);
  // Signed less-than is sign corrected by overflow.
  assign flags.signed_compare_flag = wide[7] ^ flags.overflow_flag;
  assign flags.compare_zero_flag = (wide[7:0] == 8'h00);

endmodule // sub_unit
`default_nettype wire

// *** core/axil_slave.sv ***
// AXI4-Lite slave front end turning bus beats into register strobes.
`timescale 1ns/1ns
`default_nettype none
module axil_slave
(
  // Clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus
  input wire alu_pkg::axil_req_t bus_req,
  output alu_pkg::axil_rsp_t bus_rsp,
  // Register write strobe
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  // Register read
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  import alu_pkg::*;
  `include "alu_cfg.svh"

  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } slave_state_t;

  slave_state_t s_r;
  slave_state_t s_nxt;

  // Address and data are taken in either order; nothing new is taken
  // while a write answer is still pending, so one write is in flight.
  assign bus_rsp.awready = ~s_r.aw_held & ~s_r.bvalid;
  assign bus_rsp.wready = ~s_r.w_held & ~s_r.bvalid;
  assign bus_rsp.bvalid = s_r.bvalid;
  assign bus_rsp.bresp = s_r.bresp;
  assign bus_rsp.arready = ~s_r.rvalid;
  assign bus_rsp.rvalid = s_r.rvalid;
  assign bus_rsp.rdata = s_r.rdata;
  assign bus_rsp.rresp = s_r.rresp;

  // Strobes toward the register file.
  assign wr_en = s_r.aw_held & s_r.w_held;
  assign wr_addr = s_r.awaddr;
  assign wr_data = s_r.wdata;
  assign wr_strb = s_r.wstrb;
  assign rd_addr = bus_req.araddr;

  // Next state of both channels.
  always_comb
  begin
    s_nxt = s_r;
    if (bus_req.awvalid && bus_rsp.awready)
    begin
      s_nxt.aw_held = 1'b1;
      s_nxt.awaddr = bus_req.awaddr;
    end
    if (bus_req.wvalid && bus_rsp.wready)
    begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = bus_req.wdata;
      s_nxt.wstrb = bus_req.wstrb;
    end
    if (wr_en)
    begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_r.bvalid && bus_req.bready)
      s_nxt.bvalid = 1'b0;
    if (bus_req.arvalid && bus_rsp.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_data;
      s_nxt.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_r.rvalid && bus_req.rready)
      s_nxt.rvalid = 1'b0;
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

endmodule // axil_slave
`default_nettype wire

// *** core/alu_exec.sv ***
// Execution datapath for skip, subtract and nibble-swap instructions.
//
// Behaviour
// - Nonzero skip reads, rewrites byte, skips if nonzero
// - Taken skip inserts one dummy cycle
// - Zero byte: no skip, continue normally
// - Accumulator minus memory into accumulator
// - Carry cleared on borrow, else set
// - Subtracts update all six status flags
// - Memory-destination subtract writes difference to memory
// - Immediate subtract uses literal, result in accumulator
// - Swap exchanges nibbles, writes byte back
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module alu_exec
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire alu_pkg::axil_req_t bus_req,
  output alu_pkg::axil_rsp_t bus_rsp,
  // Decoder side
  input wire alu_pkg::op_req_t op_in,
  output logic op_ready,
  output logic skip_next,
  output logic dummy_cycle,
  // Data memory side
  output alu_pkg::mem_req_t mem_out,
  input wire logic [7:0] mem_rd_data,
  // Core state
  output logic [7:0] accumulator,
  output alu_pkg::flags_t flags
);
  import alu_pkg::*;
  `include "alu_cfg.svh"

  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------

  typedef enum logic [1:0] {
    idle_st,
    read_st,
    exec_st,
    dummy_st
  } exec_state_t;

  typedef struct packed {
    exec_state_t st;
    op_t op;
    logic [7:0] addr;
    logic [7:0] literal;
    logic [7:0] acc;
    flags_t flags;
    logic enable;
    logic [7:0] skip_count;
    mem_req_t mem;
    logic skip;
  } core_state_t;

  core_state_t s_r;
  core_state_t s_nxt;

  logic [1:0] rst_sync_r;
  logic rst_n;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;

  logic [7:0] operand;
  logic [7:0] difference;
  flags_t sub_flags;
  logic [7:0] swapped;
  logic take_skip;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------

  // Release is synchronised so every flop on rst_n leaves reset on the same edge.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // True for the four implemented word offsets; shared by both channels.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `ACC_OFFSET) || (a == `STATUS_OFFSET) ||
             (a == `CTRL_OFFSET) || (a == `INFO_OFFSET);
  endfunction

  // True for instructions that fetch an operand from data memory.
  function automatic logic reads_memory(input op_t o);
    reads_memory = (o != subtract_imm_op);
  endfunction

  // True for instructions that produce a difference and flags.
  function automatic logic is_subtract(input op_t o);
    is_subtract = (o == subtract_acc_op) || (o == subtract_to_memory_op) ||
                  (o == subtract_imm_op);
  endfunction

  // ----------------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------------

  axil_slave u_bus
  (
    .clk(clk),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .bus_rsp(bus_rsp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(mapped(wr_addr)),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(mapped(rd_addr))
  );

  // Read multiplexer; unmapped offsets return zero with an error answer.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `ACC_OFFSET: rd_data[7:0] = s_r.acc;
      `STATUS_OFFSET: rd_data[`STATUS_WIDTH-1:0] = s_r.flags;
      `CTRL_OFFSET: rd_data[`CTRL_ENABLE_BIT] = s_r.enable;
      `INFO_OFFSET:
      begin
        rd_data[7:0] = s_r.skip_count;
        rd_data[`INFO_BUSY_BIT] = (s_r.st != idle_st);
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------------

  assign operand = (s_r.op == subtract_imm_op) ? s_r.literal : mem_rd_data;

  sub_unit u_sub
  (
    .minuend(s_r.acc),
    .subtrahend(operand),
    .difference(difference),
    .flags(sub_flags)
  );

  assign swapped = {mem_rd_data[3:0], mem_rd_data[7:4]};

  assign take_skip = (s_r.op == skip_if_nonzero_op) &&
                     (mem_rd_data != 8'h00);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------

  // A new instruction is accepted only when idle and software enabled it.
  assign op_ready = (s_r.st == idle_st) && s_r.enable;

  // Next state. Register writes from software land first so that an
  // instruction finishing in the same cycle overrides them; the core's
  // own result is the newer architectural value.
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.mem.rd_en = 1'b0;
    s_nxt.mem.wr_en = 1'b0;
    s_nxt.skip = 1'b0;

    // Software access to the control and state registers.
    if (wr_en && wr_strb[0])
    begin
      case (wr_addr)
        `ACC_OFFSET: s_nxt.acc = wr_data[7:0];
        `STATUS_OFFSET: s_nxt.flags = wr_data[`STATUS_WIDTH-1:0];
        `CTRL_OFFSET: s_nxt.enable = wr_data[`CTRL_ENABLE_BIT];
        default: s_nxt.acc = s_nxt.acc;
      endcase
    end

    unique case (s_r.st)
      idle_st:
      begin
        if (op_in.valid && op_ready)
        begin
          s_nxt.op = op_in.op;
          s_nxt.addr = op_in.addr;
          s_nxt.literal = op_in.literal;
          s_nxt.mem.addr = op_in.addr;
          if (reads_memory(op_in.op))
          begin
            s_nxt.mem.rd_en = 1'b1;
            s_nxt.st = read_st;
          end
          else
            s_nxt.st = exec_st;
        end
      end

      // Memory samples the address here; data is back next cycle.
      read_st:
        s_nxt.st = exec_st;

      exec_st:
      begin
        s_nxt.st = idle_st;
        if (is_subtract(s_r.op))
          s_nxt.flags = sub_flags;
        unique case (s_r.op)
          skip_if_nonzero_op:
          begin
            s_nxt.mem.wr_en = 1'b1;
            s_nxt.mem.wdata = mem_rd_data;
            if (take_skip)
            begin
              s_nxt.skip = 1'b1;
              s_nxt.skip_count = s_r.skip_count + 8'h01;
              s_nxt.st = dummy_st;
            end
          end
          subtract_acc_op,
          subtract_imm_op:
            s_nxt.acc = difference;
          subtract_to_memory_op:
          begin
            s_nxt.mem.wr_en = 1'b1;
            s_nxt.mem.wdata = difference;
          end
          swap_nibbles_op:
          begin
            s_nxt.mem.wr_en = 1'b1;
            s_nxt.mem.wdata = swapped;
          end
          default: s_nxt.st = idle_st;
        endcase
      end

      dummy_st:
        s_nxt.st = idle_st;
    endcase
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.st <= idle_st;
      s_r.op <= skip_if_nonzero_op;
      s_r.acc <= `ACC_RESET;
      s_r.flags <= `FLAGS_RESET;
      s_r.enable <= `ENABLE_RESET;
      s_r.skip_count <= `SKIP_COUNT_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // All from flops; skip_next and dummy_cycle coincide in the dummy cycle.
  assign mem_out = s_r.mem;
  assign accumulator = s_r.acc;
  assign flags = s_r.flags;
  assign skip_next = s_r.skip;
  assign dummy_cycle = (s_r.st == dummy_st);

endmodule // alu_exec
`default_nettype wire

// *** testbench/alu_exec_monitor.sv ***
// Port-level assertions for the ALU execution block.
`timescale 1ns/1ns
`default_nettype none
module alu_exec_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Decoder and memory side
  input wire alu_pkg::op_req_t op_in,
  input wire logic op_ready,
  input wire logic skip_next,
  input wire logic dummy_cycle,
  input wire alu_pkg::mem_req_t mem_out,
  input wire logic [7:0] mem_rd_data,
  // Core state
  input wire logic [7:0] accumulator,
  input wire alu_pkg::flags_t flags
);
  import alu_pkg::*;
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic take;
  // An instruction starts on an edge where both sides agree.
  assign take = op_in.valid && op_ready;
  // A memory operand is fetched from the decoded address one edge on.
  chk_read_addr: assert property (
    take && op_in.op != subtract_imm_op |-> ##1 mem_out.rd_en
    && mem_out.addr == $past(op_in.addr))
    else $error("memory read address wrong");
  // Memory forms finish three edges after the take, immediates two.
  chk_skip_write: assert property (
    take && op_in.op == skip_if_nonzero_op |-> ##3 mem_out.wr_en
    && mem_out.wdata == $past(mem_rd_data)
    && skip_next == ($past(mem_rd_data) != 8'h00))
    else $error("skip rewrite or decision wrong");
  chk_skip_dummy: assert property (
    skip_next |-> dummy_cycle ##1 !dummy_cycle)
    else $error("dummy cycle not exactly one");
  chk_suba_acc: assert property (
    take && op_in.op == subtract_acc_op |-> ##3 !mem_out.wr_en
    && accumulator == $past(accumulator) - $past(mem_rd_data))
    else $error("acc minus memory wrong");
  chk_imm_carry: assert property (
    take && op_in.op == subtract_imm_op |-> ##2 flags.carry_flag
    == ($past(accumulator) >= $past(op_in.literal, 2)))
    else $error("carry wrong");
  chk_keep_flags: assert property (
    take && op_in.op inside {skip_if_nonzero_op, swap_nibbles_op}
    |-> ##4 flags == $past(flags, 4))
    else $error("flags changed by skip or swap");
  chk_subtract_to_memory_op_write: assert property (
    take && op_in.op == subtract_to_memory_op |-> ##3 mem_out.wr_en
    && mem_out.wdata == $past(accumulator) - $past(mem_rd_data)
    && $stable(accumulator))
    else $error("memory subtract wrong");
  chk_imm_result: assert property (
    take && op_in.op == subtract_imm_op |-> ##2 accumulator
    == $past(accumulator) - $past(op_in.literal, 2))
    else $error("immediate subtract wrong");
  chk_swap_write: assert property (
    take && op_in.op == swap_nibbles_op |-> ##1 mem_out.rd_en ##2
    mem_out.wr_en && mem_out.wdata ==
    {$past(mem_rd_data[3:0]), $past(mem_rd_data[7:4])})
    else $error("swap wrong");
  chk_zero_flags: assert property (
    take && op_in.op == subtract_imm_op |-> ##2 flags.zero_flag
    == (accumulator == 8'h00) && flags.compare_zero_flag == flags.zero_flag)
    else $error("zero flags wrong");
  cover property (skip_next);
  cover property (take && op_in.op == swap_nibbles_op);
  cover property (take && op_in.op == subtract_to_memory_op);
endmodule // alu_exec_monitor
bind alu_exec alu_exec_monitor u_alu_exec_monitor (.clk, .rstn, .op_in,
  .op_ready, .skip_next, .dummy_cycle, .mem_out, .mem_rd_data,
  .accumulator, .flags);
`default_nettype wire

// *** testbench/test_subtract_swap_skip_alu_ops.sv ***
// Self-checking bench for the ALU execution block.
`timescale 1ns/1ns
`default_nettype none
`include "alu_cfg.svh"
module test_subtract_swap_skip_alu_ops;
  import alu_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  axil_req_t bus_req = '0;
  axil_rsp_t bus_rsp;
  op_req_t op_in = '0;
  logic op_ready, skip_next, dummy_cycle;
  mem_req_t mem_out;
  logic [7:0] mem_rd_data = 8'h00;
  logic [7:0] accumulator, wr_v, acc_m;
  flags_t flags, flags_m;
  logic [7:0] skips_m = 8'h00;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int wr_n, sk_n, seed;

  alu_exec u_alu_exec (.clk, .rstn, .bus_req, .bus_rsp, .op_in, .op_ready,
    .skip_next, .dummy_cycle, .mem_out, .mem_rd_data, .accumulator, .flags);

  // ----
  // Clock, cycle cap and memory-side watch
  // ----
  always #50 clk = ~clk;
  // A hung handshake would stall forever, so the run is capped.
  always @(posedge clk)
  begin
    cyc++;
    if (mem_out.wr_en === 1'b1)
    begin
      wr_n++;
      wr_v = mem_out.wdata;
    end
    if (skip_next === 1'b1)
      sk_n++;
    if (cyc == 4000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic check(logic [31:0] got, logic [31:0] exp, string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s: %h vs %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Reference subtract: {cz,sc,ov,z,ac,c} then the 8-bit difference.
  function automatic logic [13:0] sub_m(logic [7:0] a, logic [7:0] b);
    logic [7:0] d;
    logic ov;
    d = a - b;
    ov = (a[7] ^ b[7]) & (d[7] ^ a[7]);
    return {d == 8'h00, d[7] ^ ov, ov, d == 8'h00, a[3:0] >= b[3:0],
      a >= b, d};
  endfunction

  // Write strobes are seen only at edges; reading any earlier races.
  task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    bus_req.awaddr <= a;
    bus_req.wdata <= d;
    bus_req.wstrb <= 4'hf;
    bus_req.awvalid <= 1'b1;
    bus_req.wvalid <= 1'b1;
    bus_req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (bus_rsp.awready === 1'b1)
        bus_req.awvalid <= 1'b0;
      if (bus_rsp.wready === 1'b1)
        bus_req.wvalid <= 1'b0;
    end
    while ((bus_req.awvalid | bus_req.wvalid) && ++n < 20);
    while (bus_rsp.bvalid !== 1'b1 && ++n < 20)
      @(posedge clk);
    bus_req.bready <= 1'b0;
    check(bus_rsp.bresp, er, "bresp");
  endtask

  task automatic axr(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    bus_req.araddr <= a;
    bus_req.arvalid <= 1'b1;
    bus_req.rready <= 1'b1;
    do
      @(posedge clk);
    while (bus_rsp.arready !== 1'b1 && ++n < 20);
    bus_req.arvalid <= 1'b0;
    do
      @(posedge clk);
    while (bus_rsp.rvalid !== 1'b1 && ++n < 20);
    bus_req.rready <= 1'b0;
    check(bus_rsp.rdata, ed, "rdata");
    check(bus_rsp.rresp, er, "rresp");
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
      @(posedge clk);
    while (op_ready !== 1'b1 && ++n < 20);
  endtask

  // Issue one instruction, let it finish, compare with the model.
  task automatic run_op(op_t o, logic [7:0] lit, logic [7:0] d);
    logic [13:0] r;
    logic [7:0] wexp;
    logic we, sk;
    r = sub_m(acc_m, o == subtract_imm_op ? lit : d);
    we = o != subtract_acc_op && o != subtract_imm_op;
    sk = o == skip_if_nonzero_op && d != 8'h00;
    wexp = o == subtract_to_memory_op ? r[7:0] : d;
    if (o == swap_nibbles_op)
      wexp = {d[3:0], d[7:4]};
    @(posedge clk);
    wr_n = 0;
    sk_n = 0;
    op_in <= '{1'b1, o, 8'($urandom), lit};
    mem_rd_data <= d;
    wait_ready();
    op_in.valid <= 1'b0;
    wait_ready();
    @(posedge clk);
    if (o == subtract_acc_op || o == subtract_imm_op)
      acc_m = r[7:0];
    if (!we || o == subtract_to_memory_op)
      flags_m = r[13:8];
    skips_m += 8'(sk);
    check(accumulator, acc_m, "acc");
    check(flags, flags_m, "flags");
    check(wr_n, we, "writes");
    if (we)
      check(wr_v, wexp, "wdata");
    check(sk_n, sk, "skip");
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    seed = $urandom(94722);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    axr(`ACC_OFFSET, 32'h0, `RESP_OKAY);
    axr(`STATUS_OFFSET, 32'h0, `RESP_OKAY);
    axr(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
    axw(8'h10, 32'h5a, `RESP_SLVERR);
    axr(8'h10, 32'h0, `RESP_SLVERR);
    axw(`ACC_OFFSET, 32'h5a, `RESP_OKAY);
    axw(`STATUS_OFFSET, 32'h3f, `RESP_OKAY);
    axw(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
    @(posedge clk);
    check(op_ready, 1'b0, "disabled");
    axw(`CTRL_OFFSET, 32'h1, `RESP_OKAY);
    acc_m = 8'h5a;
    flags_m = 6'h3f;
    $display("test registers done");
    // Zero byte, equal operands, a borrow and a swap first.
    run_op(skip_if_nonzero_op, 8'h00, 8'h00);
    run_op(skip_if_nonzero_op, 8'h00, 8'h80);
    run_op(subtract_acc_op, 8'h00, 8'h5a);
    run_op(subtract_imm_op, 8'h01, 8'h00);
    run_op(subtract_to_memory_op, 8'h00, 8'h80);
    run_op(swap_nibbles_op, 8'h00, 8'h3c);
    $display("test directed done");
    repeat (60)
      run_op(op_t'($urandom_range(4)), 8'($urandom), 8'($urandom));
    $display("test random done");
    axr(`INFO_OFFSET, {24'h0, skips_m}, `RESP_OKAY);
    axr(`STATUS_OFFSET, {26'h0, flags_m}, `RESP_OKAY);
    $display("test readback done");
    summarize();
  end
endmodule // test_subtract_swap_skip_alu_ops
`default_nettype wire
